// File: core/cpu_regs_map.svh
/*
  Constants for the cpu register set: reset values, direct page span, stack frame
  sizes. Assumes inclusion by the design modules.
*/
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH
`define ACC_RESET        16'h0000
`define IDX_RESET        16'h0000
`define STACK_RESET      16'h0000
`define FETCH_CTR_RESET  16'h0000
`define BANK_RESET       8'h00
`define DPAGE_RESET      16'h0000
`define IRQ_FRAME_BYTES  16'h0005
`define CALL_FRAME_LONG  16'h0003
`define CALL_FRAME_SHORT 16'h0002
`define DPAGE_SPAN       16'h0100
`endif

// File: core/cpu_regs_pkg.sv
/*
  Types for the cpu register set.
  Assumes cpu_regs_map.svh for numeric constants.
*/
package cpu_regs_pkg;
  // register selects for load and read
  typedef enum logic [2:0] {
    SEL_ACC_A, SEL_ACC_B, SEL_IDX_X, SEL_IDX_Y,
    SEL_STACK, SEL_DPAGE, SEL_OPBANK, SEL_NONE
  } reg_sel_t;
  // stack frame kinds
  typedef enum logic [1:0] {
    FRAME_IRQ, FRAME_CALL_LONG, FRAME_CALL_SHORT
  } frame_t;
  // program counter update kinds
  typedef enum logic [1:0] {
    PC_HOLD, PC_INC, PC_ADD, PC_LOAD
  } pc_op_t;
endpackage : cpu_regs_pkg

// File: core/stack_sequencer.sv
/*
  Stack push/pop sequencer: emits byte addresses and data for
  interrupt and call frames, one byte per cycle.
  Assumes the caller holds frame contents stable during a sequence.
*/
`timescale 1ns/1ps
`include "cpu_regs_map.svh"
module stack_sequencer
  import cpu_regs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        push_go,
  input  wire logic        pop_go,
  input  wire frame_t      frame,
  input  wire logic [15:0] sp_in,
  input  wire logic [39:0] frame_bytes,
  input  wire logic [7:0]  pop_data,
  output logic             busy,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic [39:0]      popped,
  output logic             done,
  output logic [15:0]      sp_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} seq_state_t;
  seq_state_t  state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [2:0]  len_q, len_d;
  logic [15:0] sp_q, sp_d;
  logic [39:0] pop_q, pop_d;
  logic        done_q, done_d;

  function automatic logic [2:0] frame_len(input frame_t f);
    case (f)
      FRAME_IRQ:       frame_len = 3'(`IRQ_FRAME_BYTES);
      FRAME_CALL_LONG: frame_len = 3'(`CALL_FRAME_LONG);
      default:         frame_len = 3'(`CALL_FRAME_SHORT);
    endcase
  endfunction : frame_len

  ////////////////////////////////////////////////////////////////////
  // next state; push order is bank, pc hi, pc lo, flags hi, flags lo
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    sp_d    = sp_q;
    pop_d   = pop_q;
    done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (push_go) begin
          state_d = ST_PUSH;
          len_d   = frame_len(frame);
          cnt_d   = 3'h0;
          sp_d    = sp_in;
        end else if (pop_go) begin
          state_d = ST_POP;
          len_d   = frame_len(frame);
          cnt_d   = 3'h0;
          sp_d    = sp_in;
          pop_d   = 40'h0;
        end
      end
      // RQ7: one byte per decrement
      ST_PUSH: begin
        sp_d  = sp_q - 16'h0001;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == len_q - 3'h1) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      // RQ8: reverse order restore
      ST_POP: begin
        sp_d  = sp_q + 16'h0001;
        cnt_d = cnt_q + 3'h1;
        pop_d = {pop_q[31:0], pop_data};
        if (cnt_q == len_q - 3'h1) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      len_q   <= 3'h0;
      sp_q    <= `STACK_RESET;
      pop_q   <= 40'h0;
      done_q  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      sp_q    <= sp_d;
      pop_q   <= pop_d;
      done_q  <= done_d;
    end
  end

  // byte pushed: frame_bytes[39:32] first, shortened frames use top bytes
  always_comb begin
    mem_wdata = frame_bytes[39 - 8*cnt_q -: 8];
  end
  assign busy     = (state_q != ST_IDLE);
  assign mem_wr   = (state_q == ST_PUSH);
  // pop pre-increments: read address is sp+1
  assign mem_rd   = (state_q == ST_POP);
  assign mem_addr = (state_q == ST_POP) ? sp_q + 16'h0001 : sp_q;
  assign popped   = pop_q;
  assign done     = done_q;
  assign sp_out   = sp_q;
endmodule : stack_sequencer

// File: core/cpu_register_set.sv
/*
  Programmer-visible register set: accumulators, index registers,
  stack pointer, fetch counter and bank, operand bank, direct page base.
  Assumes an instruction sequencer drives the load and step controls.
*/
// Behaviour
// RQ1: accumulator a 16 bits, width by data flag
// RQ2: accumulator b mirrors a, same width flag
// RQ3: index x 16 bits, width by index flag
// RQ4: index y like x, same flag
// RQ5: block move source is bank3 and x
// RQ6: block move destination is bank2 and y
// RQ7: interrupt pushes five bytes, stack minus five
// RQ8: return restores reverse order, stack restored
// RQ9: call stacks like interrupt without flags
// RQ10: software must initialise stack pointer
// RQ11: fetch counter holds low 16 fetch bits
// RQ12: counter increment carry bumps fetch bank
// RQ13: add or subtract carry/borrow adjusts bank
// RQ14: single-chip software keeps banks at zero
// RQ15: operand bank forms high operand byte
// RQ16: direct page covers 256 bytes from base
// RQ17: base FF01 and up spans into bank 1
// RQ18: zero low base byte means fast path
// RQ19: fetch address is bank then counter
`timescale 1ns/1ps
`include "cpu_regs_map.svh"
module cpu_register_set
  import cpu_regs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        data_width_8,
  input  wire logic        index_width_8,
  input  wire reg_sel_t    load_sel,
  input  wire logic [15:0] load_data,
  input  wire reg_sel_t    read_sel,
  output logic [15:0]      read_data,
  input  wire pc_op_t      pc_op,
  input  wire logic [15:0] pc_operand,
  input  wire logic        pc_subtract,
  input  wire logic [7:0]  bank_load,
  input  wire logic        block_move,
  input  wire logic [7:0]  move_byte2,
  input  wire logic [7:0]  move_byte3,
  output logic [23:0]      move_src_addr,
  output logic [23:0]      move_dst_addr,
  input  wire logic [7:0]  dp_offset,
  output logic [23:0]      dp_addr,
  output logic             dp_fast,
  input  wire logic [15:0] operand_low,
  output logic [23:0]      operand_addr,
  output logic [23:0]      fetch_addr,
  input  wire logic        irq_enter,
  input  wire logic        call_enter,
  input  wire logic        call_long,
  input  wire logic        irq_return,
  input  wire logic        call_return,
  input  wire logic [15:0] processor_flags_word,
  input  wire logic [7:0]  stack_rdata,
  output logic             stack_wr,
  output logic             stack_rd,
  output logic [15:0]      stack_addr,
  output logic [7:0]       stack_wdata,
  output logic             stack_busy,
  output logic             frame_done,
  output logic [15:0]      flags_restored
);
  logic [15:0] acc_a_q, acc_a_d, acc_b_q, acc_b_d;
  logic [15:0] idx_x_q, idx_x_d, idx_y_q, idx_y_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] fetch_counter_q, fetch_counter_d;
  logic [7:0]  fetch_bank_q, fetch_bank_d;
  logic [7:0]  operand_bank_q, operand_bank_d;
  logic [15:0] direct_page_base_q, direct_page_base_d;
  logic [15:0] flags_q, flags_d;
  logic        ret_irq_q, ret_irq_d, popping_q, popping_d;
  frame_t      frame;
  frame_t      frame_q, frame_d, frame_use;
  logic [39:0] frame_bytes, popped;
  logic        seq_busy, seq_done;
  logic [15:0] seq_sp;
  logic        push_go, pop_go;

  // width-aware write: 8-bit mode keeps the high byte untouched
  function automatic logic [15:0] sized_write(input logic [15:0] old,
                                              input logic [15:0] val,
                                              input logic        narrow);
    sized_write = narrow ? {old[15:8], val[7:0]} : val;
  endfunction : sized_write

  // width-aware read: high byte reads zero in 8-bit mode
  function automatic logic [15:0] sized_read(input logic [15:0] val,
                                             input logic        narrow);
    sized_read = narrow ? {8'h00, val[7:0]} : val;
  endfunction : sized_read

  ////////////////////////////////////////////////////////////////////
  // frame selection for the stack sequencer
  always_comb begin
    // RQ9: call frames omit flags, short call omits bank
    if (irq_enter || irq_return)
      frame = FRAME_IRQ;
    else if (call_long)
      frame = FRAME_CALL_LONG;
    else
      frame = FRAME_CALL_SHORT;
    // RQ7: bank, counter hi, counter lo, flags hi, flags lo
    // request lines last one cycle, so bytes follow the latched kind
    frame_use = seq_busy ? frame_q : frame;
    if (frame_use == FRAME_CALL_SHORT)
      frame_bytes = {fetch_counter_q, 24'h0};
    else
      frame_bytes = {fetch_bank_q, fetch_counter_q, processor_flags_word};
  end
  // new requests ignored while a frame is in flight or ending;
  // the stack pointer only settles in the cycle after done
  assign push_go = !seq_busy && !seq_done && (irq_enter || call_enter);
  assign pop_go  = !seq_busy && !seq_done && !push_go && (irq_return || call_return);

  stack_sequencer u_seq (
    .mclk        (mclk),
    .resetn      (resetn),
    .ce          (ce),
    .push_go     (push_go),
    .pop_go      (pop_go),
    .frame       (frame),
    .sp_in       (sp_q),
    .frame_bytes (frame_bytes),
    .pop_data    (stack_rdata),
    .busy        (seq_busy),
    .mem_wr      (stack_wr),
    .mem_rd      (stack_rd),
    .mem_addr    (stack_addr),
    .mem_wdata   (stack_wdata),
    .popped      (popped),
    .done        (seq_done),
    .sp_out      (seq_sp)
  );

  ////////////////////////////////////////////////////////////////////
  // data registers next values
  always_comb begin
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    idx_x_d = idx_x_q;
    idx_y_d = idx_y_q;
    operand_bank_d     = operand_bank_q;
    direct_page_base_d = direct_page_base_q;
    case (load_sel)
      // RQ1: width from data flag
      SEL_ACC_A:  acc_a_d = sized_write(acc_a_q, load_data, data_width_8);
      // RQ2: same flag as accumulator a
      SEL_ACC_B:  acc_b_d = sized_write(acc_b_q, load_data, data_width_8);
      // RQ3: width from index flag
      SEL_IDX_X:  idx_x_d = sized_write(idx_x_q, load_data, index_width_8);
      // RQ4: same index flag
      SEL_IDX_Y:  idx_y_d = sized_write(idx_y_q, load_data, index_width_8);
      // RQ16: any base value allowed
      SEL_DPAGE:  direct_page_base_d = load_data;
      SEL_OPBANK: operand_bank_d = load_data[7:0];
      default:    ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // stack pointer, fetch counter and bank next values
  always_comb begin
    logic [16:0] sum;
    sum             = 17'h0;
    sp_d            = sp_q;
    fetch_counter_d = fetch_counter_q;
    fetch_bank_d    = fetch_bank_q;
    flags_d         = flags_q;
    ret_irq_d       = ret_irq_q;
    popping_d       = popping_q;
    frame_d         = frame_q;
    // RQ10: software loads the stack, no hardware init value implied
    if (load_sel == SEL_STACK)
      sp_d = load_data;
    if (pop_go) begin
      ret_irq_d = irq_return;
      popping_d = 1'b1;
    end else if (push_go)
      popping_d = 1'b0;
    // kind held for the whole frame
    if (push_go || pop_go)
      frame_d = frame;
    // RQ7: sequencer returns stack minus frame length
    if (seq_busy)
      sp_d = seq_sp;
    if (seq_done) begin
      sp_d = seq_sp;
      // RQ8: restored stack equals pre-interrupt value
      if (popping_q && ret_irq_q) begin
        // last byte read sits lowest, so each high byte is below its low byte
        fetch_bank_d    = popped[7:0];
        fetch_counter_d = {popped[15:8], popped[23:16]};
        flags_d         = {popped[31:24], popped[39:32]};
      end else if (popping_q && frame_q == FRAME_CALL_LONG) begin
        fetch_bank_d    = popped[7:0];
        fetch_counter_d = {popped[15:8], popped[23:16]};
      end else if (popping_q) begin
        fetch_counter_d = {popped[7:0], popped[15:8]};
      end
    end else begin
      case (pc_op)
        // RQ12: increment carry bumps bank
        PC_INC: begin
          sum             = {1'b0, fetch_counter_q} + 17'h00001;
          fetch_counter_d = sum[15:0];
          if (sum[16])
            fetch_bank_d = fetch_bank_q + 8'h01;
        end
        // RQ13: carry or borrow moves bank
        PC_ADD: begin
          if (pc_subtract)
            sum = {1'b0, fetch_counter_q} - {1'b0, pc_operand};
          else
            sum = {1'b0, fetch_counter_q} + {1'b0, pc_operand};
          fetch_counter_d = sum[15:0];
          if (sum[16])
            fetch_bank_d = pc_subtract ? fetch_bank_q - 8'h01
                                       : fetch_bank_q + 8'h01;
        end
        // RQ11: full 16-bit counter load
        PC_LOAD: begin
          fetch_counter_d = pc_operand;
          fetch_bank_d    = bank_load;
        end
        default: ;
      endcase
    end
  end

  // all state frozen while ce is low
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_a_q            <= `ACC_RESET;
      acc_b_q            <= `ACC_RESET;
      idx_x_q            <= `IDX_RESET;
      idx_y_q            <= `IDX_RESET;
      sp_q               <= `STACK_RESET;
      fetch_counter_q    <= `FETCH_CTR_RESET;
      fetch_bank_q       <= `BANK_RESET;
      operand_bank_q     <= `BANK_RESET;
      direct_page_base_q <= `DPAGE_RESET;
      flags_q            <= 16'h0000;
      ret_irq_q          <= 1'b0;
      popping_q          <= 1'b0;
      frame_q            <= FRAME_IRQ;
    end else if (ce) begin
      acc_a_q            <= acc_a_d;
      acc_b_q            <= acc_b_d;
      idx_x_q            <= idx_x_d;
      idx_y_q            <= idx_y_d;
      sp_q               <= sp_d;
      fetch_counter_q    <= fetch_counter_d;
      fetch_bank_q       <= fetch_bank_d;
      operand_bank_q     <= operand_bank_d;
      direct_page_base_q <= direct_page_base_d;
      flags_q            <= flags_d;
      ret_irq_q          <= ret_irq_d;
      popping_q          <= popping_d;
      frame_q            <= frame_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, width-aware
  always_comb begin
    case (read_sel)
      SEL_ACC_A:  read_data = sized_read(acc_a_q, data_width_8);
      SEL_ACC_B:  read_data = sized_read(acc_b_q, data_width_8);
      SEL_IDX_X:  read_data = sized_read(idx_x_q, index_width_8);
      SEL_IDX_Y:  read_data = sized_read(idx_y_q, index_width_8);
      SEL_STACK:  read_data = sp_q;
      SEL_DPAGE:  read_data = direct_page_base_q;
      SEL_OPBANK: read_data = {8'h00, operand_bank_q};
      default:    read_data = 16'h0000;
    endcase
  end

  // address formation; move addresses zero when no block move to keep bus quiet
  always_comb begin
    logic [16:0] dp_sum;
    dp_sum = {1'b0, direct_page_base_q} + {9'h000, dp_offset};
    // RQ5: source bank from third byte
    move_src_addr = block_move ? {move_byte3, idx_x_q} : 24'h000000;
    // RQ6: destination bank from second byte
    move_dst_addr = block_move ? {move_byte2, idx_y_q} : 24'h000000;
    // RQ17: carry runs into bank 1, no wrap
    dp_addr = {7'h00, dp_sum};
    // RQ18: low base byte zero is the fast path
    dp_fast = (direct_page_base_q[7:0] == 8'h00);
    // RQ15: operand bank on top
    operand_addr = {operand_bank_q, operand_low};
    // RQ19: bank concatenated with counter
    fetch_addr = {fetch_bank_q, fetch_counter_q};
  end

  assign stack_busy     = seq_busy;
  assign frame_done     = seq_done;
  assign flags_restored = flags_q;
endmodule : cpu_register_set

// File: dv/cpu_regs_asserts.sv
/*
  Port-level checker for cpu_register_set.
  Assumes one clock, mclk, and the synchronous active-low resetn.
*/
`timescale 1ns/1ps
module cpu_regs_asserts
  import cpu_regs_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        data_width_8,
  input wire logic        index_width_8,
  input wire reg_sel_t    read_sel,
  input wire logic [15:0] read_data,
  input wire pc_op_t      pc_op,
  input wire logic [15:0] pc_operand,
  input wire logic        pc_subtract,
  input wire logic [7:0]  bank_load,
  input wire logic        block_move,
  input wire logic [7:0]  move_byte2,
  input wire logic [7:0]  move_byte3,
  input wire logic [23:0] move_src_addr,
  input wire logic [23:0] move_dst_addr,
  input wire logic [7:0]  dp_offset,
  input wire logic [23:0] dp_addr,
  input wire logic        dp_fast,
  input wire logic [15:0] operand_low,
  input wire logic [23:0] operand_addr,
  input wire logic [23:0] fetch_addr,
  input wire logic        irq_enter,
  input wire logic        call_enter,
  input wire logic        call_long,
  input wire logic        irq_return,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0]  stack_wdata,
  input wire logic        stack_wr,
  input wire logic        stack_rd,
  input wire logic        stack_busy,
  input wire logic        frame_done
);
  // requests only count while no frame is in flight
  wire idle = ce & ~stack_busy & ~frame_done;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_push5; stack_wr [*5] ##1 frame_done; endsequence
  sequence s_push3; stack_wr [*3] ##1 frame_done; endsequence
  sequence s_pop5;  stack_rd [*5] ##1 frame_done; endsequence
  //////////////////////////////////////////////////////////////////
  a_acc_narrow: assert property (data_width_8 && read_sel == SEL_ACC_A |->
    read_data[15:8] == 8'h00) else $error("acc high byte not zero");
  a_idx_narrow: assert property (index_width_8 && read_sel == SEL_IDX_Y |->
    read_data[15:8] == 8'h00) else $error("index high byte not zero");
  a_move_src: assert property (block_move |-> move_src_addr[23:16] == move_byte3)
    else $error("source bank wrong");
  a_move_dst: assert property (block_move |-> move_dst_addr[23:16] == move_byte2)
    else $error("destination bank wrong");
  a_dp_span: assert property (read_sel == SEL_DPAGE |->
    dp_addr == {8'h00, read_data} + {16'h0000, dp_offset}) else $error("dp address wrong");
  a_dp_fast: assert property (read_sel == SEL_DPAGE |->
    dp_fast == (read_data[7:0] == 8'h00)) else $error("dp fast flag wrong");
  a_op_bank: assert property (read_sel == SEL_OPBANK |->
    operand_addr == {read_data[7:0], operand_low}) else $error("operand address wrong");
  a_pc_inc: assert property (idle && pc_op == PC_INC |=>
    fetch_addr == $past(fetch_addr) + 24'h1) else $error("increment wrong");
  a_pc_add: assert property (idle && pc_op == PC_ADD |=> fetch_addr ==
    ($past(pc_subtract) ? $past(fetch_addr) - {8'h00, $past(pc_operand)}
                        : $past(fetch_addr) + {8'h00, $past(pc_operand)}))
    else $error("add or subtract wrong");
  a_pc_load: assert property (idle && pc_op == PC_LOAD |=>
    fetch_addr == {$past(bank_load), $past(pc_operand)}) else $error("load wrong");
  a_irq_frame: assert property (idle && irq_enter |=> s_push5)
    else $error("interrupt frame wrong");
  a_call_long: assert property (idle && call_enter && !irq_enter && call_long
    |=> s_push3) else $error("call frame wrong");
  a_irq_pop: assert property (idle && irq_return && !irq_enter && !call_enter
    |=> s_pop5) else $error("return frame wrong");
  a_push_step: assert property (stack_wr && $past(stack_wr) |->
    stack_addr == $past(stack_addr) - 16'h1) else $error("push address step wrong");
endmodule : cpu_regs_asserts
//////////////////////////////////////////////////////////////////
bind cpu_register_set cpu_regs_asserts i_cpu_regs_asserts (.*);

// File: dv/tb_top.sv
/*
  Self-checking bench for cpu_register_set.
  Assumes the bench models the stack memory itself.
*/
`timescale 1ns/1ps
module tb_top;
  import cpu_regs_pkg::*;
  typedef struct packed {reg_sel_t s; logic w; logic [15:0] d; logic [15:0] e;} row_t;
  logic mclk, resetn, ce, data_width_8, index_width_8, pc_subtract, block_move;
  logic irq_enter, call_enter, call_long, irq_return, call_return;
  logic stack_wr, stack_rd, stack_busy, frame_done, dp_fast;
  reg_sel_t load_sel, read_sel;
  pc_op_t pc_op;
  logic [15:0] load_data, read_data, pc_operand, operand_low, processor_flags_word;
  logic [15:0] stack_addr, flags_restored;
  logic [7:0] bank_load, move_byte2, move_byte3, dp_offset, stack_wdata;
  logic [23:0] move_src_addr, move_dst_addr, dp_addr, operand_addr, fetch_addr;
  logic [7:0] mem [0:65535];
  logic [7:0] wq [$];
  int n_mismatch, tests_run;
  wire logic [7:0] stack_rdata = mem[stack_addr];
  row_t rows [8] = '{'{SEL_ACC_A, 0, 16'h1234, 16'h1234}, '{SEL_ACC_A, 1, 16'habcd, 16'h00cd},
    '{SEL_ACC_B, 0, 16'hbeef, 16'hbeef}, '{SEL_ACC_B, 1, 16'h1357, 16'h0057},
    '{SEL_IDX_X, 0, 16'h5678, 16'h5678}, '{SEL_IDX_X, 1, 16'h9abc, 16'h00bc},
    '{SEL_IDX_Y, 0, 16'hfedc, 16'hfedc}, '{SEL_IDX_Y, 1, 16'h2468, 16'h0068}};
  cpu_register_set i_cpu_register_set (.*);
  //////////////////////////////////////////////////////////////////
  // clock, and a stack memory that the pushes fill
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (stack_wr === 1'b1) mem[stack_addr] <= stack_wdata;
  task chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task ld(input reg_sel_t s, input logic [15:0] d);
    @(posedge mclk);
    load_sel <= s;
    load_data <= d;
    @(posedge mclk);
    load_sel <= SEL_NONE;
  endtask : ld
  task rd(input reg_sel_t s, input logic [15:0] e);
    @(posedge mclk);
    read_sel <= s;
    #1 chk(read_data, e);
  endtask : rd
  task pcop(input pc_op_t o, input logic [15:0] v, input logic s, input logic [7:0] b);
    @(posedge mclk);
    pc_op <= o;
    pc_operand <= v;
    pc_subtract <= s;
    bank_load <= b;
    @(posedge mclk);
    pc_op <= PC_HOLD;
    #1;
  endtask : pcop
  // one frame request, then count byte cycles up to the done pulse
  task frame(input logic [4:0] r, input int n);
    int c;
    int k;
    c = 0;
    k = 0;
    wq.delete();
    @(posedge mclk);
    {irq_enter, call_enter, call_long, irq_return, call_return} <= r;
    @(posedge mclk);
    {irq_enter, call_enter, call_long, irq_return, call_return} <= 5'h00;
    #1;
    chk(stack_busy, 24'h1);
    while (frame_done !== 1'b1 && k < 20) begin
      if (stack_wr === 1'b1 || stack_rd === 1'b1) c++;
      if (stack_wr === 1'b1) wq.push_back(stack_wdata);
      @(posedge mclk);
      #1;
      k++;
    end
    // registers take the popped bytes at the edge after done
    @(posedge mclk);
    #1;
    chk(24'(c), 24'(n));
  endtask : frame
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////
  // hang guard, well beyond the roughly 130 cycles of the run
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    {resetn, ce, data_width_8, index_width_8, pc_subtract, block_move} = 6'h10;
    {irq_enter, call_enter, call_long, irq_return, call_return} = 5'h00;
    load_sel = SEL_NONE;
    read_sel = SEL_NONE;
    pc_op = PC_HOLD;
    {load_data, pc_operand, operand_low, processor_flags_word} = 64'h0;
    {bank_load, move_byte2, move_byte3, dp_offset} = 32'h0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd(SEL_ACC_A, 16'h0000);
    chk(fetch_addr, 24'h000000);
    // table of loads and width-limited reads
    foreach (rows[i]) begin
      data_width_8 <= rows[i].w;
      index_width_8 <= rows[i].w;
      ld(rows[i].s, rows[i].d);
      rd(rows[i].s, rows[i].e);
    end
    // flags apart: each register follows its own width flag
    {data_width_8, index_width_8} <= 2'b10;
    rd(SEL_IDX_Y, 16'hfe68);
    rd(SEL_ACC_B, 16'h0057);
    {data_width_8, index_width_8} <= 2'b00;
    ld(SEL_IDX_X, 16'h1111);
    ld(SEL_IDX_Y, 16'h2222);
    {block_move, move_byte2, move_byte3} <= 17'h18899;
    @(posedge mclk);
    #1 chk(move_src_addr, 24'h991111);
    chk(move_dst_addr, 24'h882222);
    block_move <= 1'b0;
    ld(SEL_DPAGE, 16'hff80);
    dp_offset <= 8'h90;
    rd(SEL_DPAGE, 16'hff80);
    chk(dp_addr, 24'h010010);
    chk(dp_fast, 24'h0);
    ld(SEL_DPAGE, 16'h1200);
    rd(SEL_DPAGE, 16'h1200);
    chk({dp_addr[23:1], dp_fast}, 24'h001291);
    ld(SEL_OPBANK, 16'h0034);
    operand_low <= 16'h5678;
    rd(SEL_OPBANK, 16'h0034);
    chk(operand_addr, 24'h345678);
    pcop(PC_LOAD, 16'hffff, 1'b0, 8'h12);
    pcop(PC_INC, 16'h0000, 1'b0, 8'h00);
    chk(fetch_addr, 24'h130000);
    pcop(PC_LOAD, 16'hfff8, 1'b0, 8'h13);
    pcop(PC_ADD, 16'h0010, 1'b0, 8'h00);
    chk(fetch_addr, 24'h140008);
    pcop(PC_ADD, 16'h000c, 1'b1, 8'h00);
    chk(fetch_addr, 24'h13fffc);
    // interrupt frame out and back
    ld(SEL_STACK, 16'h01ff);
    pcop(PC_LOAD, 16'h3456, 1'b0, 8'h12);
    processor_flags_word <= 16'ha5c3;
    frame(5'b10000, 5);
    chk({wq[0], wq[1], wq[2]}, 24'h123456);
    chk({wq[3], wq[4]}, 24'h00a5c3);
    rd(SEL_STACK, 16'h01fa);
    pcop(PC_LOAD, 16'h0000, 1'b0, 8'h00);
    frame(5'b00010, 5);
    chk(fetch_addr, 24'h123456);
    chk(flags_restored, 24'h00a5c3);
    rd(SEL_STACK, 16'h01ff);
    // long and short calls leave the flags off the stack
    frame(5'b01100, 3);
    chk({wq[0], wq[1], wq[2]}, 24'h123456);
    rd(SEL_STACK, 16'h01fc);
    pcop(PC_LOAD, 16'h0000, 1'b0, 8'h00);
    frame(5'b00101, 3);
    chk(fetch_addr, 24'h123456);
    frame(5'b01000, 2);
    chk({wq[0], wq[1]}, 24'h003456);
    rd(SEL_STACK, 16'h01fd);
    pcop(PC_LOAD, 16'h0000, 1'b0, 8'h12);
    frame(5'b00001, 2);
    chk(fetch_addr, 24'h123456);
    rd(SEL_STACK, 16'h01ff);
    // clock enable low must freeze a load
    ce <= 1'b0;
    ld(SEL_ACC_A, 16'h7777);
    ce <= 1'b1;
    rd(SEL_ACC_A, 16'h12cd);
    // second reset in mid-run clears the registers again
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(SEL_ACC_A, 16'h0000);
    chk(fetch_addr, 24'h000000);
    chk(operand_addr, 24'h005678);
    conclude();
  end
endmodule : tb_top
